// ---- arc_pkg.sv ----
// arc_pkg: shared constants and carrier types for the adc result
// calibration block.
// assumes a 16-bit two's complement conversion result word.
package arc_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam logic [15:0] OFS_GAIN_TRIM_1P5 = 16'h2270;
   localparam logic [15:0] OFS_OFFSET_TRIM_2 = 16'h22c8;

   // ------------------------------------------------------------------
   // field layout and reset values
   // ------------------------------------------------------------------
   localparam int TRIM_W = 15;
   localparam int TRIM_MSB = 14;
   localparam int GAIN_FRAC = 14;
   localparam int OFS_FRAC = 2;
   localparam logic [14:0] GAIN_RESET = 15'h4000;
   localparam logic [14:0] OFFSET_RESET = 15'h0000;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

   // ------------------------------------------------------------------
   // result word
   // ------------------------------------------------------------------
   localparam int RES_W = 16;
   localparam logic signed [15:0] RES_MAX = 16'sh7fff;
   localparam logic signed [15:0] RES_MIN = -16'sh8000;

   // amplifier gain setting seen with each conversion
   typedef enum logic [1:0] {
      ARC_PGA_OTHER,
      ARC_PGA_1P5,
      ARC_PGA_2
   } arc_pga_e;

   // channel class: only auxiliary inputs take gain correction
   typedef enum logic [1:0] {
      ARC_CH_AUX,
      ARC_CH_TIA,
      ARC_CH_TEMP
   } arc_chan_e;

   typedef struct packed {
      logic [15:0] data;
      arc_pga_e pga;
      arc_chan_e chan;
   } arc_sample_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } arc_bus_req_s;

endpackage : arc_pkg

// ---- arc_saturate.sv ----
// arc_saturate: clamps a wide signed value into the result word range.
// assumes the input is already scaled to result-word lsb units.
`timescale 1ns/1ps
module arc_saturate #(
   parameter int IN_W = 34,
   parameter int OUT_W = 16
) (
   input wire logic signed [IN_W-1:0] din,
   output logic signed [OUT_W-1:0] dout
);

   localparam logic signed [IN_W-1:0] HI = IN_W'((1 <<< (OUT_W-1)) - 1);
   localparam logic signed [IN_W-1:0] LO = -IN_W'(1 <<< (OUT_W-1));

   always_comb begin
      if (din > HI) begin
         dout = HI[OUT_W-1:0];
      end else if (din < LO) begin
         dout = LO[OUT_W-1:0];
      end else begin
         dout = din[OUT_W-1:0];
      end
   end

endmodule : arc_saturate

// ---- arc_calib.sv ----
// arc_calib: calibration registers and correction of adc results.
// assumes a plain register port and one sample per valid pulse from the
// converter, both on clk_sys.
//
// Operation
// - gain-1.5 word corrects aux channels only
// - gain bit 14 integer, 13:0 fraction
// - gain code zero yields zero result
// - unity code passes result; reset value
// - half-unity code halves the result
// - gain factor is code over 2^14
// - gain-2 offset is two's complement
// - offset step is quarter result lsb
// - offset codes span -4096 to +4095.75
`timescale 1ns/1ps
module arc_calib (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire arc_pkg::arc_bus_req_s bus_req,
   output logic [31:0] rdata,
   input wire logic sample_valid,
   input wire arc_pkg::arc_sample_s sample_in,
   output logic result_valid,
   output logic [15:0] conversion_result_word,
   output logic [14:0] gain_trim_pga_one_and_half_q,
   output logic [14:0] offset_trim_pga_two_q
);

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   logic [14:0] gain_trim_pga_one_and_half_r;
   logic [14:0] offset_trim_pga_two_r;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         gain_trim_pga_one_and_half_r <= arc_pkg::GAIN_RESET;
      end else if (bus_req.wr &&
                   bus_req.addr == arc_pkg::OFS_GAIN_TRIM_1P5) begin
         // upper bits of the write word are dropped
         gain_trim_pga_one_and_half_r <=
            bus_req.wdata[arc_pkg::TRIM_MSB:0];
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         offset_trim_pga_two_r <= arc_pkg::OFFSET_RESET;
      end else if (bus_req.wr &&
                   bus_req.addr == arc_pkg::OFS_OFFSET_TRIM_2) begin
         offset_trim_pga_two_r <= bus_req.wdata[arc_pkg::TRIM_MSB:0];
      end
   end

   always_comb begin
      rdata_nxt = arc_pkg::UNMAPPED_READ;
      if (bus_req.addr == arc_pkg::OFS_GAIN_TRIM_1P5) begin
         rdata_nxt = {17'h0_0000, gain_trim_pga_one_and_half_r};
      end else if (bus_req.addr == arc_pkg::OFS_OFFSET_TRIM_2) begin
         rdata_nxt = {17'h0_0000, offset_trim_pga_two_r};
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_r <= arc_pkg::UNMAPPED_READ;
      end else if (bus_req.rd) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= arc_pkg::UNMAPPED_READ;
      end
   end

   // ------------------------------------------------------------------
   // correction path
   // ------------------------------------------------------------------
   // result in quarter-lsb units, wide enough for gain x2 plus offset
   logic signed [33:0] corr_q;
   logic signed [33:0] corr_lsb;
   logic signed [15:0] corr_sat;
   logic signed [33:0] prod;
   logic use_gain;
   logic use_offset;

   always_comb begin
      use_gain = sample_in.pga == arc_pkg::ARC_PGA_1P5 &&
                 sample_in.chan == arc_pkg::ARC_CH_AUX;
      use_offset = sample_in.pga == arc_pkg::ARC_PGA_2;
      // code is unsigned magnitude over 2^14; zero code gives zero
      prod = 34'(signed'(sample_in.data)) *
             34'(signed'({1'b0, gain_trim_pga_one_and_half_r}));
      if (use_gain) begin
         // keep two fraction bits as quarter lsbs
         corr_q = prod >>> (arc_pkg::GAIN_FRAC - arc_pkg::OFS_FRAC);
      end else begin
         corr_q = 34'(signed'(sample_in.data)) <<< arc_pkg::OFS_FRAC;
      end
      if (use_offset) begin
         corr_q = corr_q + 34'(signed'(offset_trim_pga_two_r));
      end
      // truncation toward minus infinity; unity code stays exact
      corr_lsb = corr_q >>> arc_pkg::OFS_FRAC;
   end

   arc_saturate #(
      .IN_W(34),
      .OUT_W(arc_pkg::RES_W)
   ) u_sat (
      .din(corr_lsb),
      .dout(corr_sat)
   );

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         conversion_result_word <= 16'h0000;
         result_valid <= 1'b0;
      end else begin
         result_valid <= sample_valid;
         if (sample_valid) begin
            conversion_result_word <= corr_sat;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         gain_trim_pga_one_and_half_q <= arc_pkg::GAIN_RESET;
         offset_trim_pga_two_q <= arc_pkg::OFFSET_RESET;
      end else begin
         gain_trim_pga_one_and_half_q <= gain_trim_pga_one_and_half_r;
         offset_trim_pga_two_q <= offset_trim_pga_two_r;
      end
   end

   assign rdata = rdata_r;

endmodule : arc_calib

// ---- arc_calib_asserts.sv ----
// arc_calib_asserts: port checks for arc_calib.
// assumes one clock, clk_sys, and async active-high sys_rst.
`timescale 1ns/1ps
module arc_calib_chk (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire arc_pkg::arc_bus_req_s bus_req,
   input wire logic [31:0] rdata,
   input wire logic sample_valid,
   input wire arc_pkg::arc_sample_s sample_in,
   input wire logic result_valid,
   input wire logic [15:0] conversion_result_word,
   input wire logic [14:0] gain_trim_pga_one_and_half_q,
   input wire logic [14:0] offset_trim_pga_two_q
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   wire logic g1 = sample_valid && sample_in.pga == arc_pkg::ARC_PGA_1P5;
   wire logic gu = g1 && sample_in.chan == arc_pkg::ARC_CH_AUX;
   wire logic [14:0] g = gain_trim_pga_one_and_half_q;
   wire logic [15:0] r = conversion_result_word;
   // trim copies lag one cycle, so skip samples right after a write
   property p_chan; g1 && !gu |=> result_valid && r == $past(sample_in.data);
   endproperty
   a_chan: assert property (p_chan) else $error("non-aux gain");
   property p_unity; gu && g == 15'h4000 && !$past(bus_req.wr)
      |=> r == $past(sample_in.data); endproperty
   a_unity: assert property (p_unity) else $error("unity gain");
   property p_zero; gu && g == 15'h0 && !$past(bus_req.wr) |=> r == 16'h0;
   endproperty
   a_zero: assert property (p_zero) else $error("zero gain");
   property p_half; gu && g == 15'h2000 && !$past(bus_req.wr)
      && !sample_in.data[0] |=> r == {$past(sample_in.data[15]),
      $past(sample_in.data[15:1])};
   endproperty
   a_half: assert property (p_half) else $error("half gain");
   property p_other; sample_valid && sample_in.pga == arc_pkg::ARC_PGA_OTHER
      |=> r == $past(sample_in.data); endproperty
   a_other: assert property (p_other) else $error("other pga");
   property p_ofs0; sample_valid && sample_in.pga == arc_pkg::ARC_PGA_2
      && offset_trim_pga_two_q == 15'h0 && !$past(bus_req.wr)
      |=> r == $past(sample_in.data); endproperty
   a_ofs0: assert property (p_ofs0) else $error("zero offset");
   property p_rd0; !bus_req.rd |=> rdata == 32'h0; endproperty
   a_rd0: assert property (p_rd0) else $error("rdata idle");
   property p_rsv; bus_req.rd |=> rdata[31:15] == 17'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits");
endmodule : arc_calib_chk

bind arc_calib arc_calib_chk i_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .bus_req(bus_req), .rdata(rdata), .sample_valid(sample_valid),
   .sample_in(sample_in), .result_valid(result_valid),
   .conversion_result_word(conversion_result_word),
   .gain_trim_pga_one_and_half_q(gain_trim_pga_one_and_half_q),
   .offset_trim_pga_two_q(offset_trim_pga_two_q));

// ---- tb_top.sv ----
// tb_top: directed bench for arc_calib.
// assumes arc_pkg is compiled first.
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic sample_valid = 1'b0;
   logic result_valid;
   arc_pkg::arc_bus_req_s bus_req = '0;
   arc_pkg::arc_sample_s sample_in = '0;
   logic [31:0] rdata;
   logic [15:0] res;
   int bad_count = 0;
   int compares = 0;
   arc_calib i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(bus_req),
      .rdata(rdata), .sample_valid(sample_valid), .sample_in(sample_in),
      .result_valid(result_valid), .conversion_result_word(res),
      .gain_trim_pga_one_and_half_q(), .offset_trim_pga_two_q());
   initial forever #5 clk_sys = ~clk_sys;
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // w=1 writes d, w=0 reads and compares with d
   task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      bus_req <= {a, d, w, !w};
      @(posedge clk_sys);
      bus_req <= '0;
      #1;
      if (!w) chk("rdata", d, rdata);
   endtask : bus
   task smp(input logic [15:0] d, input logic [3:0] pc, input logic [15:0] e);
      @(posedge clk_sys);
      sample_valid <= 1'b1;
      sample_in <= {d, pc};
      @(posedge clk_sys);
      sample_valid <= 1'b0;
      #1;
      chk("result_valid", 32'h1, {31'h0, result_valid});
      chk("result", {16'h0, e}, {16'h0, res});
   endtask : smp
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_regs;
      bus(0, arc_pkg::OFS_GAIN_TRIM_1P5, 32'h4000);
      bus(0, arc_pkg::OFS_OFFSET_TRIM_2, 32'h0);
      bus(0, 16'h2274, 32'h0);
      bus(1, arc_pkg::OFS_GAIN_TRIM_1P5, 32'hffff_2000);
      bus(0, arc_pkg::OFS_GAIN_TRIM_1P5, 32'h2000);
      smp(16'd100, 4'h4, 16'd50);
      smp(16'd100, 4'h5, 16'd100);
      smp(16'd100, 4'h6, 16'd100);
      smp(16'd100, 4'h0, 16'd100);
   endtask : t_regs
   task t_gain;
      logic [14:0] c [6] = '{15'h0, 15'h4000, 15'h4001, 15'h3fff, 15'h1,
         15'h7fff};
      for (int i = 0; i < 6; i++) begin
         bus(1, arc_pkg::OFS_GAIN_TRIM_1P5, {17'h0, c[i]});
         smp(16'h4000, 4'h4, {1'b0, c[i]});
      end
      smp(16'd20000, 4'h4, 16'h7fff);
      smp(16'h8ad0, 4'h4, 16'h8000);
   endtask : t_gain
   task t_ofs;
      logic [14:0] c [7] = '{15'h4, 15'h1, 15'h7fff, 15'h4000, 15'h3fff,
         15'h3fff, 15'h4000};
      logic [15:0] d [7] = '{16'd10, 16'd10, 16'd10, 16'h0, 16'h0, 16'h7d00,
         16'h8ad0};
      logic [15:0] e [7] = '{16'd11, 16'd10, 16'd9, 16'hf000, 16'h0fff,
         16'h7fff, 16'h8000};
      for (int i = 0; i < 7; i++) begin
         bus(1, arc_pkg::OFS_OFFSET_TRIM_2, {17'h0, c[i]});
         smp(d[i], 4'h8, e[i]);
      end
      smp(16'd10, 4'h5, 16'd10);
      bus(0, arc_pkg::OFS_OFFSET_TRIM_2, 32'h4000);
   endtask : t_ofs
   task complete_run;
      if (bad_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_regs;
      t_gain;
      t_ofs;
      complete_run;
   end
endmodule : tb_top
